//--- logic/fbid_defines.vh
// Constants for the fourteen-bit instruction decoder
`ifndef FBID_DEFINES_VH
`define FBID_DEFINES_VH

// Oscillator periods per instruction cycle, and the phases used inside it
`define FBID_PHASES      4
`define FBID_PH_EXEC     2'h2
`define FBID_PH_FETCH    2'h3

// Fixed words and field values
`define FBID_NOP_WORD    14'h0000
`define FBID_W_RETURN    7'h08
`define FBID_W_RETURN_FROM_INTERRUPT_OP    7'h09
`define FBID_W_SLEEP     7'h63
`define FBID_W_WATCHDOG_CLEAR_OP    7'h64

// Top-level opcode classes, bits 13:12
`define FBID_CL_BYTE     2'h0
`define FBID_CL_BIT      2'h1
`define FBID_CL_JUMP     2'h2
`define FBID_CL_LIT      2'h3

// Reset values
`define FBID_RST_PC      13'h0000
`define FBID_RST_ACC     8'h00
`define FBID_RST_TO      1'h1
`define FBID_RST_PD      1'h1

`endif

//--- logic/fbid_decoder.v
// Instruction decode and execute core for a 14-bit instruction word
`timescale 1ns/1ps
`default_nettype none
// Function
// - add-register adds accumulator and file, updates carry, digit carry, zero
// - destination bit clear sends result to accumulator, set to the register
// - register AND, OR, XOR combine with accumulator, update only zero
// - subtracts give operand minus accumulator, update carry, digit carry, zero
// - decrement/increment-skip write result, skip next when zero, no flags
// - rotates shift one place through carry, change only carry
// - bit clear/set force the selected bit, no flags changed
// - bit tests discard next instruction when bit matches, two cycles
// - add-literal adds literal to accumulator, updates carry, digit carry, zero
// - literal OR, AND, XOR into accumulator, update only zero
// - load literal one cycle; return with literal two cycles; no flags
// - standby word enters standby, sets time-out, clears power-down
// - program counter change or true test costs a second no-op cycle
// - read-modify-write on the port uses pin levels, not latch
// - write to first timer count clears its assigned prescaler
// - one instruction cycle spans four oscillator periods
`include "fbid_defines.vh"

module fbid_decoder #(
  parameter [6:0] TIMER_ADDR = 7'h01,
  parameter [6:0] PORT_ADDR  = 7'h05
) (
  input  wire        CLK,
  input  wire        RSTN,
  output wire [12:0] PM_ADDR,
  input  wire [13:0] PM_DATA,
  output wire [6:0]  FILE_ADDR,
  input  wire [7:0]  FILE_RDATA,
  output reg  [7:0]  FILE_WDATA,
  output reg         FILE_WE,
  input  wire [7:0]  PORT_PINS,
  input  wire [1:0]  PAGE_SEL,
  output reg  [12:0] STACK_WDATA,
  output reg         STACK_PUSH,
  output reg         STACK_POP,
  input  wire [12:0] STACK_TOP,
  input  wire        PRESCALER_ON_TIMER,
  output reg         PRESCALER_CLR,
  output reg         WATCHDOG_CLR,
  output reg         INT_ENABLE_SET,
  input  wire        WAKE,
  output reg         STANDBY,
  output reg  [7:0]  ACC,
  output reg         FLAG_C,
  output reg         FLAG_DC,
  output reg         FLAG_Z,
  output reg         TIME_OUT_FLAG,
  output reg         POWER_DOWN_FLAG,
  output wire [1:0]  PHASE
);

  ////////////////////////////////////////////////////////////////////////////
  // Phase counter, pin synchronisers, sequencing state
  reg  [1:0]  phase_reg;
  reg  [12:0] pc_reg;
  reg  [13:0] ir_reg;
  reg         flush_reg;
  reg         hold_reg;
  reg  [7:0]  pin_s1_reg;
  reg  [7:0]  pin_s2_reg;
  reg         wake_s1_reg;
  reg         wake_s2_reg;

  wire        exec_now  = (phase_reg == `FBID_PH_EXEC) && !STANDBY;
  wire        fetch_now = (phase_reg == `FBID_PH_FETCH) && !STANDBY;
  wire [1:0]  cls       = ir_reg[13:12];
  wire [3:0]  opn       = ir_reg[11:8];
  wire        dbit      = ir_reg[7];
  wire [6:0]  faddr     = ir_reg[6:0];
  wire [7:0]  lit       = ir_reg[7:0];
  wire [2:0]  bsel      = ir_reg[9:7];

  assign PM_ADDR   = pc_reg;
  assign FILE_ADDR = faddr;
  assign PHASE     = phase_reg;

  // pin levels read
  // The port operand comes from the synchronised pins so a driven-low input writes back zero
  wire [7:0]  opr = (faddr == PORT_ADDR) ? pin_s2_reg : FILE_RDATA;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and datapath
  reg  [7:0]  res;
  reg  [7:0]  add_a;
  reg  [7:0]  add_b;
  reg         add_ci;
  reg         wr_f;
  reg         wr_w;
  reg         upd_z;
  reg         upd_cdc;
  reg         upd_c;
  reg         c_rot;
  reg         skip;
  reg         jump;
  reg         push;
  reg         pop;
  reg         return_from_interrupt_op;
  reg         sleep_op;
  reg         wdt_op;
  reg  [12:0] jaddr;
  reg  [8:0]  sum;
  reg  [4:0]  nsum;

  always @* begin
    res      = 8'h00;
    add_a    = ACC;
    add_b    = opr;
    add_ci   = 1'b0;
    wr_f     = 1'b0;
    wr_w     = 1'b0;
    upd_z    = 1'b0;
    upd_cdc  = 1'b0;
    upd_c    = 1'b0;
    c_rot    = FLAG_C;
    skip     = 1'b0;
    jump     = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    return_from_interrupt_op   = 1'b0;
    sleep_op = 1'b0;
    wdt_op   = 1'b0;
    jaddr    = STACK_TOP;
    if ((cls == `FBID_CL_BYTE && opn == 4'h2) || (cls == `FBID_CL_LIT && opn[3:1] == 3'h6)) begin
      add_a  = ~ACC;
      add_ci = 1'b1;
    end
    if (cls == `FBID_CL_LIT) begin
      add_b = lit;
    end
    sum  = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_ci};
    nsum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
    case (cls)
      `FBID_CL_BYTE: begin
        wr_f  = dbit;
        wr_w  = !dbit;
        upd_z = 1'b1;
        case (opn)
          4'h0: begin
            upd_z = 1'b0;
            wr_w  = 1'b0;
            res   = ACC;
            if (!dbit) begin
              case (faddr)
                `FBID_W_RETURN: begin
                  jump = 1'b1;
                  pop  = 1'b1;
                end
                `FBID_W_RETURN_FROM_INTERRUPT_OP: begin
                  jump   = 1'b1;
                  pop    = 1'b1;
                  return_from_interrupt_op = 1'b1;
                end
                `FBID_W_SLEEP:  sleep_op = 1'b1;
                `FBID_W_WATCHDOG_CLEAR_OP: wdt_op = 1'b1;
                default:        res = ACC;
              endcase
            end
          end
          4'h1: res = 8'h00;
          4'h2, 4'h7: begin
            // add with carry and digit carry
            res     = sum[7:0];
            upd_cdc = 1'b1;
          end
          4'h3: res = opr - 8'h01;
          4'h4: res = ACC | opr;
          4'h5: res = ACC & opr;
          4'h6: res = ACC ^ opr;
          4'h8: res = opr;
          4'h9: res = ~opr;
          4'hA: res = opr + 8'h01;
          4'hB, 4'hF: begin
            res   = (opn == 4'hB) ? opr - 8'h01 : opr + 8'h01;
            upd_z = 1'b0;
            skip  = (res == 8'h00);
          end
          4'hC: begin
            res   = {FLAG_C, opr[7:1]};
            c_rot = opr[0];
            upd_c = 1'b1;
            upd_z = 1'b0;
          end
          4'hD: begin
            res   = {opr[6:0], FLAG_C};
            c_rot = opr[7];
            upd_c = 1'b1;
            upd_z = 1'b0;
          end
          default: begin
            res   = {opr[3:0], opr[7:4]};
            upd_z = 1'b0;
          end
        endcase
        // Clear accumulator is the clear opcode with the destination bit clear; its file field is ignored
        if (opn == 4'h1 && !dbit) begin
          wr_w = 1'b1;
        end
      end
      `FBID_CL_BIT: begin
        res  = opn[2] ? (opr | (8'h01 << bsel)) : (opr & ~(8'h01 << bsel));
        wr_f = !opn[3];
        skip = opn[3] && (opr[bsel] == opn[2]);
      end
      `FBID_CL_JUMP: begin
        jump  = 1'b1;
        push  = !opn[3];
        jaddr = {PAGE_SEL, ir_reg[10:0]};
      end
      default: begin
        res  = lit;
        wr_w = 1'b1;
        case (opn)
          4'h8: begin
            res   = ACC | lit;
            upd_z = 1'b1;
          end
          4'h9: begin
            res   = ACC & lit;
            upd_z = 1'b1;
          end
          4'hA: begin
            res   = ACC ^ lit;
            upd_z = 1'b1;
          end
          4'hB: wr_w = 1'b0;
          4'hC, 4'hD, 4'hE, 4'hF: begin
            res     = sum[7:0];
            upd_cdc = 1'b1;
            upd_z   = 1'b1;
          end
          default: begin
            jump = (opn[3:2] == 2'h1);
            pop  = (opn[3:2] == 2'h1);
          end
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and state update
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_reg       <= 2'h0;
      pc_reg          <= `FBID_RST_PC;
      ir_reg          <= `FBID_NOP_WORD;
      flush_reg       <= 1'b0;
      hold_reg        <= 1'b0;
      pin_s1_reg      <= 8'h00;
      pin_s2_reg      <= 8'h00;
      wake_s1_reg     <= 1'b0;
      wake_s2_reg     <= 1'b0;
      FILE_WDATA      <= 8'h00;
      FILE_WE         <= 1'b0;
      STACK_WDATA     <= `FBID_RST_PC;
      STACK_PUSH      <= 1'b0;
      STACK_POP       <= 1'b0;
      PRESCALER_CLR   <= 1'b0;
      WATCHDOG_CLR    <= 1'b0;
      INT_ENABLE_SET  <= 1'b0;
      STANDBY         <= 1'b0;
      ACC             <= `FBID_RST_ACC;
      FLAG_C          <= 1'b0;
      FLAG_DC         <= 1'b0;
      FLAG_Z          <= 1'b0;
      TIME_OUT_FLAG   <= `FBID_RST_TO;
      POWER_DOWN_FLAG <= `FBID_RST_PD;
    end else begin
      phase_reg      <= phase_reg + 2'h1;
      pin_s1_reg     <= PORT_PINS;
      pin_s2_reg     <= pin_s1_reg;
      wake_s1_reg    <= WAKE;
      wake_s2_reg    <= wake_s1_reg;
      FILE_WE        <= 1'b0;
      STACK_PUSH     <= 1'b0;
      STACK_POP      <= 1'b0;
      PRESCALER_CLR  <= 1'b0;
      WATCHDOG_CLR   <= 1'b0;
      INT_ENABLE_SET <= 1'b0;
      if (STANDBY && wake_s2_reg) begin
        STANDBY <= 1'b0;
      end
      if (exec_now) begin
        FILE_WDATA     <= res;
        FILE_WE        <= wr_f;
        STACK_WDATA    <= pc_reg;
        STACK_PUSH     <= push;
        STACK_POP      <= pop;
        INT_ENABLE_SET <= return_from_interrupt_op;
        WATCHDOG_CLR   <= wdt_op;
        PRESCALER_CLR  <= wr_f && (faddr == TIMER_ADDR) && PRESCALER_ON_TIMER;
        if (wr_w) begin
          ACC <= res;
        end
        if (upd_z) begin
          FLAG_Z <= (res == 8'h00);
        end
        if (upd_cdc) begin
          FLAG_C  <= sum[8];
          FLAG_DC <= nsum[4];
        end
        if (upd_c) begin
          FLAG_C <= c_rot;
        end
        if (sleep_op) begin
          TIME_OUT_FLAG   <= 1'b1;
          POWER_DOWN_FLAG <= 1'b0;
        end
        if (wdt_op) begin
          TIME_OUT_FLAG   <= 1'b1;
          POWER_DOWN_FLAG <= 1'b1;
        end
        flush_reg <= jump || skip;
        hold_reg  <= jump;
        if (jump) begin
          pc_reg <= jaddr;
        end
      end
      if (fetch_now) begin
        // A skipped word is fetched and dropped; a jump target is held and fetched next
        ir_reg    <= flush_reg ? `FBID_NOP_WORD : PM_DATA;
        flush_reg <= 1'b0;
        hold_reg  <= 1'b0;
        if (!hold_reg) begin
          pc_reg <= pc_reg + 13'h0001;
        end
        // Standby starts after this fetch, or the wake would run the standby word again
        if (sleep_op) begin
          STANDBY <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- sim/fbid_decoder_props.sv
// Port-level property checker for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module fbid_props #(
  parameter [6:0] TIMER_ADDR = 7'h01
) (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic [12:0] PM_ADDR,
  input wire logic [6:0]  FILE_ADDR,
  input wire logic        FILE_WE,
  input wire logic [1:0]  PAGE_SEL,
  input wire logic        STACK_PUSH,
  input wire logic        STACK_POP,
  input wire logic [12:0] STACK_TOP,
  input wire logic        PRESCALER_ON_TIMER,
  input wire logic        PRESCALER_CLR,
  input wire logic        WATCHDOG_CLR,
  input wire logic        WAKE,
  input wire logic        STANDBY,
  input wire logic [7:0]  ACC,
  input wire logic        TIME_OUT_FLAG,
  input wire logic        POWER_DOWN_FLAG,
  input wire logic [1:0]  PHASE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////////
  property p_we;
    FILE_WE |-> PHASE == 2'h3 ##1 !FILE_WE;
  endproperty
  a_we: assert property (p_we) else $error("file write outside one phase-3 clock");
  property p_acc;
    $changed(ACC) |-> PHASE == 2'h3;
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator moved off the execute edge");
  property p_addr;
    $changed(FILE_ADDR) |-> PHASE == 2'h0;
  endproperty
  a_addr: assert property (p_addr) else $error("file address moved off the fetch edge");
  property p_pclr;
    PRESCALER_CLR |-> FILE_WE && FILE_ADDR == TIMER_ADDR && $past(PRESCALER_ON_TIMER);
  endproperty
  a_pclr: assert property (p_pclr) else $error("prescaler clear without timer write");
  property p_call;
    STACK_PUSH |-> !STACK_POP && PM_ADDR[12:11] == $past(PAGE_SEL);
  endproperty
  a_call: assert property (p_call) else $error("call target page wrong");
  property p_ret;
    STACK_POP |-> PM_ADDR == $past(STACK_TOP);
  endproperty
  a_ret: assert property (p_ret) else $error("return address not loaded");
  property p_sleep;
    $rose(STANDBY) |-> TIME_OUT_FLAG && !POWER_DOWN_FLAG;
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby status bits wrong");
  property p_wdt;
    WATCHDOG_CLR |-> TIME_OUT_FLAG && POWER_DOWN_FLAG;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear status bits wrong");
  property p_wake;
    $rose(WAKE) |-> ##[1:12] !STANDBY;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not end standby");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind fbid_decoder fbid_props #(.TIMER_ADDR(TIMER_ADDR)) u_props (
  .CLK(CLK), .RSTN(RSTN), .PM_ADDR(PM_ADDR), .FILE_ADDR(FILE_ADDR), .FILE_WE(FILE_WE),
  .PAGE_SEL(PAGE_SEL), .STACK_PUSH(STACK_PUSH), .STACK_POP(STACK_POP),
  .STACK_TOP(STACK_TOP), .PRESCALER_ON_TIMER(PRESCALER_ON_TIMER),
  .PRESCALER_CLR(PRESCALER_CLR), .WATCHDOG_CLR(WATCHDOG_CLR), .WAKE(WAKE),
  .STANDBY(STANDBY), .ACC(ACC), .TIME_OUT_FLAG(TIME_OUT_FLAG),
  .POWER_DOWN_FLAG(POWER_DOWN_FLAG), .PHASE(PHASE));
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        CLK, RSTN, WAKE, PRESCALER_ON_TIMER, FILE_WE, STACK_PUSH, STACK_POP;
  logic        PRESCALER_CLR, WATCHDOG_CLR, INT_ENABLE_SET, STANDBY;
  logic        FLAG_C, FLAG_DC, FLAG_Z, TIME_OUT_FLAG, POWER_DOWN_FLAG, c, dc, z, to, pd, sk;
  logic [13:0] PM_DATA, tpl [0:32], msk [0:32];
  logic [12:0] PM_ADDR, STACK_TOP;
  logic [7:0]  FILE_RDATA, FILE_WDATA, PORT_PINS, ACC, a;
  logic [6:0]  FILE_ADDR;
  logic [1:0]  PAGE_SEL, PHASE;
  logic [40:0] q [$];
  logic [40:0] e_note;
  integer      seed = 92841;
  integer      miscompares = 0;
  integer      samples_checked = 0;
  integer      n;
  fbid_decoder uut (
    .CLK(CLK), .RSTN(RSTN), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .FILE_ADDR(FILE_ADDR),
    .FILE_RDATA(FILE_RDATA), .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE),
    .PORT_PINS(PORT_PINS), .PAGE_SEL(PAGE_SEL), .STACK_WDATA(), .STACK_PUSH(STACK_PUSH),
    .STACK_POP(STACK_POP), .STACK_TOP(STACK_TOP), .PRESCALER_ON_TIMER(PRESCALER_ON_TIMER),
    .PRESCALER_CLR(PRESCALER_CLR), .WATCHDOG_CLR(WATCHDOG_CLR),
    .INT_ENABLE_SET(INT_ENABLE_SET), .WAKE(WAKE), .STANDBY(STANDBY), .ACC(ACC),
    .FLAG_C(FLAG_C), .FLAG_DC(FLAG_DC), .FLAG_Z(FLAG_Z), .TIME_OUT_FLAG(TIME_OUT_FLAG),
    .POWER_DOWN_FLAG(POWER_DOWN_FLAG), .PHASE(PHASE));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] addf(input logic [7:0] x, input logic [7:0] y,
                                      input logic ci);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    return {s[8], lo[4], s[7:0]};
  endfunction
  task cmp(input logic [40:0] e, input logic [40:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Drives one word at the execute edge, so it is fetched next and runs a cycle later
  task automatic step(input logic [13:0] w);
    logic [7:0]  rd, pins, opd, r;
    logic [12:0] top, pcx;
    logic [1:0]  pg;
    logic        pon, pcv, we, psh, pop, wdc, ien;
    {pins, rd} = 16'($random(seed));
    {pon, pg, top} = 16'($random(seed));
    do @(negedge CLK); while (PHASE !== 2'h2);
    @(posedge CLK);
    PM_DATA <= w;
    FILE_RDATA <= rd;
    PORT_PINS <= pins;
    STACK_TOP <= top;
    PAGE_SEL <= pg;
    PRESCALER_ON_TIMER <= pon;
    opd = (w[6:0] == 7'h05) ? pins : rd;
    {r, pcx, pcv, we, psh, pop, wdc, ien} = '0;
    if (sk) sk = 1'b0;
    else case (w[13:12])
      2'h0: begin
        case (w[11:8])
          4'h7: {c, dc, r} = addf(a, opd, 1'b0);
          4'h2: {c, dc, r} = addf(opd, ~a, 1'b1);
          4'h5: r = a & opd;
          4'h4: r = a | opd;
          4'h6: r = a ^ opd;
          4'hB: r = opd - 8'h01;
          4'hF: r = opd + 8'h01;
          4'hD: {c, r} = {opd, c};
          4'hC: {r, c} = {c, opd};
          4'h0: r = a;
          4'h3: r = opd - 8'h01;
          4'h8: r = opd;
          4'h9: r = ~opd;
          4'hA: r = opd + 8'h01;
          4'hE: r = {opd[3:0], opd[7:4]};
          default: r = 8'h00;
        endcase
        if (w[11:8] inside {4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'h1, 4'h3, 4'h8, 4'h9, 4'hA})
          z = (r == 8'h00);
        if (w[11:8] inside {4'hB, 4'hF}) sk = (r == 8'h00);
        if (w[11:7] == 5'h00) begin
          pop = (w[6:1] == 6'h04);
          ien = (w[6:0] == 7'h09);
          wdc = (w[6:0] == 7'h64);
          if (w[6:0] == 7'h63) {to, pd} = 2'b10;
          if (wdc) {to, pd} = 2'b11;
        end else if (w[7]) we = 1'b1;
        else a = r;
      end
      2'h1: begin
        r = w[10] ? opd | (8'h01 << w[9:7]) : opd & ~(8'h01 << w[9:7]);
        we = !w[11];
        if (w[11]) sk = (opd[w[9:7]] == w[10]);
      end
      2'h2: begin
        pcv = 1'b1;
        pcx = {pg, w[10:0]};
        psh = !w[11];
      end
      default: begin
        if (w[11:9] == 3'h7) {c, dc, a} = addf(a, w[7:0], 1'b0);
        else if (w[11:9] == 3'h6) {c, dc, a} = addf(w[7:0], ~a, 1'b1);
        else if (w[11:8] == 4'h8) a = a | w[7:0];
        else if (w[11:8] == 4'h9) a = a & w[7:0];
        else if (w[11:8] == 4'hA) a = a ^ w[7:0];
        else if (w[11] == 1'b0) a = w[7:0];
        if (w[11] && w[11:8] != 4'hB) z = (a == 8'h00);
        pop = (w[11:10] == 2'h1);
      end
    endcase
    pcv = pcv | pop;
    if (pop) pcx = top;
    sk = sk | pcv;
    q.push_back({pcv, pcx, a, c, dc, z, to, pd, we, we ? r : 8'h00, psh, pop, wdc, ien,
                 we && w[6:0] == 7'h01 && pon});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge CLK) begin
    if (PHASE === 2'h3 && STANDBY === 1'b0 && q.size() > 0) begin
      e_note = q.pop_front();
      cmp(e_note, {e_note[40], e_note[40] ? PM_ADDR : 13'h0000, ACC, FLAG_C, FLAG_DC, FLAG_Z,
          TIME_OUT_FLAG, POWER_DOWN_FLAG, FILE_WE, FILE_WE ? FILE_WDATA : 8'h00, STACK_PUSH,
          STACK_POP, WATCHDOG_CLR, INT_ENABLE_SET, PRESCALER_CLR});
    end
  end
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Limit of 1875 instruction cycles of 16 ns, about three times the some 630 the run needs
  initial begin
    #30000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    tpl = '{14'h0700, 14'h0500, 14'h0400, 14'h0600, 14'h0200, 14'h0B00, 14'h0F00, 14'h0D00,
            14'h0C00, 14'h0100, 14'h0080, 14'h1000, 14'h1400, 14'h1800, 14'h1C00, 14'h2800,
            14'h2000, 14'h3000, 14'h3400, 14'h3800, 14'h3900, 14'h3A00, 14'h3C00, 14'h3E00,
            14'h0008, 14'h0009, 14'h0064, 14'h0000, 14'h0300, 14'h0800, 14'h0900,
            14'h0A00, 14'h0E00};
    // File field kept to 0..7 so the timer and port addresses come up often
    msk = '{14'h0087, 14'h0087, 14'h0087, 14'h0087, 14'h0087, 14'h0087, 14'h0087, 14'h0087,
            14'h0087, 14'h0087, 14'h0007, 14'h0387, 14'h0387, 14'h0387, 14'h0387, 14'h07FF,
            14'h07FF, 14'h03FF, 14'h03FF, 14'h00FF, 14'h00FF, 14'h00FF, 14'h01FF, 14'h01FF,
            14'h0000, 14'h0000, 14'h0000, 14'h0060, 14'h0087, 14'h0087, 14'h0087,
            14'h0087, 14'h0087};
    {RSTN, WAKE, PRESCALER_ON_TIMER, PM_DATA, FILE_RDATA, PORT_PINS} = '0;
    {STACK_TOP, PAGE_SEL, a, c, dc, z, sk} = '0;
    {to, pd} = 2'b11;
    q.push_back({14'h0000, 8'h00, 5'b00011, 14'h0000});
    repeat (5) @(posedge CLK);
    RSTN <= 1'b1;
    for (n = 0; n < 620; n++)
      step(tpl[n % 33] | (msk[n % 33] & 14'($random(seed))));
    // A no-op absorbs any skip left by the last random word
    step(14'h0000);
    step(14'h0063);
    step(14'h0000);
    repeat (12) @(negedge CLK);
    cmp(41'h1, {40'h0, STANDBY});
    @(posedge CLK);
    WAKE <= 1'b1;
    repeat (16) @(negedge CLK);
    cmp(41'h0, {40'h0, STANDBY});
    cmp(41'h0, 41'(q.size()));
    tally_and_finish;
  end
endmodule
`default_nettype wire
